/* src/nps_sequencer.v */
// Serial NOR program/erase command sequencer with suspend and resume
// Operation
// - Page program: opcode, 24-bit address, data
// - Program/erase needs write latch armed
// - Data address wraps within 256-byte page
// - Select must rise on byte boundary
// - Chip erase select rises after opcode
// - Busy held during self-timed cycle
// - Completion clears write latch
// - Protected target blocks program or erase
// - Any protection refuses chip erase
// - Quad page program needs quad enable
// - Sector erase clears 4 KiB sector
// - Block 64 KiB, half block 32 KiB
// - C7h or 60h erase whole array
// - Suspend only during busy sector/block/page
// - Suspend ignored during chip erase
// - Erase suspended rejects erase, status writes
// - Program suspended rejects program, 01h/31h status writes
// - Other sectors allowed while suspended; this model starts only a page program, and only in erase suspend
// - Commands on suspended sector are ignored
// - Suspend sets flag, drops busy promptly
// - Resume clears flag, busy within 200 ns
// - Opcode 06h arms write latch
// - Status read answered at any time
`timescale 1ns/10ps
`include "nps_regs.vh"
module nps_sequencer
#(
  parameter PAGE_CYCLES  = 24'd8000,
  parameter SECT_CYCLES  = 24'd20000,
  parameter HALF_CYCLES  = 24'd40000,
  parameter BLOCK_CYCLES = 24'd60000,
  parameter CHIP_CYCLES  = 24'd200000,
  parameter SUS_CYCLES   = 24'd100,
  parameter TW           = 24
)
(
  input  wire        MCLK_IN,
  input  wire        RESET_N_IN,
  input  wire        SEL_N_IN,
  input  wire        SCLK_IN,
  input  wire        LANE_ZERO_IN,
  input  wire        LANE_ONE_IN,
  input  wire        LANE_TWO_IN,
  input  wire        LANE_THREE_IN,
  output reg         LANE_ONE_OUT,
  output wire        LANE_ONE_OE_N_OUT,
  input  wire        QUAD_LANES_ON_IN,
  input  wire        PROTECT_FROM_BOTTOM_IN,
  input  wire        SMALL_GRANULE_PROTECT_IN,
  input  wire        PROTECT_SIZE_BIT2_IN,
  input  wire        PROTECT_SIZE_BIT1_IN,
  input  wire        PROTECT_SIZE_BIT0_IN,
  input  wire        TARGET_PROTECTED_IN,
  output reg  [23:0] TARGET_ADDR_OUT,
  output reg         WRITE_LATCH_ARMED_OUT,
  output reg         BUSY_OUT,
  output reg         SUSPENDED_FLAG_OUT,
  output reg         PAGE_WR_OUT,
  output reg  [7:0]  PAGE_WR_INDEX_OUT,
  output reg  [7:0]  PAGE_WR_DATA_OUT,
  output reg         START_OUT,
  output reg  [2:0]  START_KIND_OUT,
  output reg         DONE_OUT
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_RUN  = 4'b0010;
  localparam ST_SUSP = 4'b0100;
  localparam ST_NEST = 4'b1000;
  localparam [TW-1:0] RES_CYCLES = (`NPS_RESUME_NS / `NPS_CLK_NS);

  wire       sel_n;
  wire       sel_rise;
  wire       sel_fall;
  wire       sclk_rise;
  wire       sclk_fall;
  wire [3:0] lanes;

  nps_sync #(.WIDTH(1)) u_sel
  (
    .clk_in   (MCLK_IN),
    .async_in (SEL_N_IN),
    .sync_out (sel_n),
    .rise_out (sel_rise),
    .fall_out (sel_fall)
  );
  nps_sync #(.WIDTH(1)) u_clk
  (
    .clk_in   (MCLK_IN),
    .async_in (SCLK_IN),
    .sync_out (),
    .rise_out (sclk_rise),
    .fall_out (sclk_fall)
  );
  nps_sync #(.WIDTH(4)) u_lane
  (
    .clk_in   (MCLK_IN),
    .async_in ({LANE_THREE_IN, LANE_TWO_IN, LANE_ONE_IN, LANE_ZERO_IN}),
    .sync_out (lanes),
    .rise_out (),
    .fall_out ()
  );

  // Frame shifter
  reg  [7:0]  shift;
  reg  [2:0]  bitcnt;
  reg  [5:0]  bytecnt;
  reg  [7:0]  opcode;
  reg  [23:0] addr;
  reg  [7:0]  index;
  reg         data_seen;
  reg         quad;
  reg         byte_done;
  reg  [7:0]  status_sh;
  wire [2:0]  step      = quad ? 3'd4 : 3'd1;
  wire [7:0]  next_shift = quad ? {shift[3:0], lanes} : {shift[6:0], lanes[0]};
  wire [2:0]  next_bitcnt = bitcnt + step;
  wire        byte_end   = (next_bitcnt == 3'd0);
  wire        in_frame   = !sel_n;

  // Sequencer state
  reg  [3:0]    state;
  reg           nest_load;
  wire          nest_done;
  reg  [2:0]    kind;
  reg  [23:0]   run_addr;
  reg  [TW-1:0] sus_wait;
  reg           resuming;
  reg           tmr_load;
  reg  [TW-1:0] tmr_count;
  wire          tmr_done;

  nps_timer #(.WIDTH(TW)) u_tmr
  (
    .clk_in     (MCLK_IN),
    .reset_n_in (RESET_N_IN),
    .load_in    (tmr_load),
    .count_in   (tmr_count),
    .run_in     (state == ST_RUN && !resuming),
    .done_out   (tmr_done)
  );
  // Separate counter so a nested page program keeps the suspended erase's remaining time
  nps_timer #(.WIDTH(TW)) u_nest
  (
    .clk_in     (MCLK_IN),
    .reset_n_in (RESET_N_IN),
    .load_in    (nest_load),
    .count_in   (tmr_count),
    .run_in     (state == ST_NEST),
    .done_out   (nest_done)
  );

  always @(posedge MCLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      shift     <= 8'h00;
      bitcnt    <= 3'd0;
      bytecnt   <= 6'd0;
      opcode    <= 8'h00;
      addr      <= 24'h000000;
      index     <= 8'h00;
      data_seen <= 1'b0;
      quad      <= 1'b0;
      byte_done <= 1'b1;
    end
    else if (sel_fall)
    begin
      bitcnt    <= 3'd0;
      bytecnt   <= 6'd0;
      byte_done <= 1'b1;
      data_seen <= 1'b0;
      quad      <= 1'b0;
    end
    else if (in_frame && sclk_rise)
    begin
      shift     <= next_shift;
      bitcnt    <= next_bitcnt;
      byte_done <= byte_end;
      if (byte_end)
      begin
        if (bytecnt != 6'h3f)
          bytecnt <= bytecnt + 6'd1;
        if (bytecnt == 6'd0)
        begin
          opcode <= next_shift;
          quad   <= (next_shift == `NPS_OP_QPAGE) && QUAD_LANES_ON_IN;
        end
        else if (bytecnt < 6'd4)
        begin
          addr <= {addr[15:0], next_shift};
          if (bytecnt == 6'd3)
            index <= next_shift;
        end
        else
        begin
          data_seen <= 1'b1;
          index     <= index + 8'd1;
        end
      end
    end
  end

  // Page buffer writes go to the low eight bits only, wrapping in the page
  always @(posedge MCLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      PAGE_WR_OUT       <= 1'b0;
      PAGE_WR_INDEX_OUT <= 8'h00;
      PAGE_WR_DATA_OUT  <= 8'h00;
    end
    else
    begin
      PAGE_WR_OUT <= in_frame && sclk_rise && byte_end && bytecnt >= 6'd4 && state != ST_RUN &&
                     (opcode == `NPS_OP_PAGE || opcode == `NPS_OP_QPAGE);
      PAGE_WR_INDEX_OUT <= index;
      PAGE_WR_DATA_OUT  <= next_shift;
    end
  end

  // Status read: shifted out MSB first on falling serial clock
  assign LANE_ONE_OE_N_OUT = !(in_frame && opcode == `NPS_OP_RDSR && bytecnt != 6'd0);
  always @(posedge MCLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      status_sh    <= 8'h00;
      LANE_ONE_OUT <= 1'b0;
    end
    else if (in_frame && sclk_rise && byte_end && (bytecnt == 6'd0 ? next_shift : opcode) == `NPS_OP_RDSR)
    begin
      status_sh <= {SUSPENDED_FLAG_OUT, 5'h00, WRITE_LATCH_ARMED_OUT, BUSY_OUT};
    end
    else if (in_frame && sclk_fall && opcode == `NPS_OP_RDSR && bytecnt != 6'd0)
    begin
      LANE_ONE_OUT <= status_sh[7];
      status_sh    <= {status_sh[6:0], status_sh[7]};
    end
  end

  // Command decode at select rise
  wire any_prot   = PROTECT_SIZE_BIT2_IN | PROTECT_SIZE_BIT1_IN | PROTECT_SIZE_BIT0_IN;
  wire is_page    = opcode == `NPS_OP_PAGE || (opcode == `NPS_OP_QPAGE && QUAD_LANES_ON_IN);
  wire is_chip    = opcode == `NPS_OP_CHIP_A || opcode == `NPS_OP_CHIP_B;
  wire is_sect    = opcode == `NPS_OP_SECT;
  wire is_half    = opcode == `NPS_OP_HALF;
  wire is_block   = opcode == `NPS_OP_BLOCK;
  wire is_erase   = is_sect || is_half || is_block || is_chip || opcode == `NPS_OP_SECERASE;
  wire is_prog    = is_page || opcode == `NPS_OP_SECPROG;
  wire is_wrsr    = opcode == `NPS_OP_WRSR1 || opcode == `NPS_OP_WRSR2 || opcode == `NPS_OP_WRSR3;
  wire susp_erase = state == ST_SUSP && kind != `NPS_KIND_PAGE;
  wire susp_prog  = state == ST_SUSP && kind == `NPS_KIND_PAGE;
  wire same_sect  = state == ST_SUSP &&
                    addr[23:`NPS_SECT_LSB] == run_addr[23:`NPS_SECT_LSB];
  wire blocked    = (susp_erase && (is_erase || opcode == `NPS_OP_WRSR3 || is_wrsr)) ||
                    (susp_prog && (is_prog || opcode == `NPS_OP_WRSR1 || opcode == `NPS_OP_WRSR2)) ||
                    (same_sect && !is_chip);
  wire framing_ok = byte_done && bitcnt == 3'd0;
  wire addr_ok    = bytecnt == 6'd4 && !is_page;
  wire page_ok    = is_page && data_seen;
  wire chip_ok    = is_chip && bytecnt == 6'd1;
  wire legal      = framing_ok && (addr_ok && (is_sect || is_half || is_block) || page_ok || chip_ok);
  wire prot_fail  = is_chip ? (any_prot || susp_prog) : TARGET_PROTECTED_IN;
  wire accept     = sel_rise && state != ST_RUN && state != ST_NEST && WRITE_LATCH_ARMED_OUT && legal &&
                    !prot_fail && !blocked && !(is_chip && state == ST_SUSP);
  wire one_byte   = sel_rise && framing_ok && bytecnt == 6'd1;
  wire do_susp    = one_byte && opcode == `NPS_OP_SUSPEND && state == ST_RUN && !resuming &&
                    !SUSPENDED_FLAG_OUT && kind != `NPS_KIND_CHIP;
  wire do_resume  = one_byte && opcode == `NPS_OP_RESUME && state == ST_SUSP && !BUSY_OUT;
  wire do_wren    = one_byte && opcode == `NPS_OP_WREN && state != ST_RUN && state != ST_NEST;

  reg [2:0] next_kind;
  always @*
  begin
    next_kind = `NPS_KIND_NONE;
    if (is_page)
      next_kind = `NPS_KIND_PAGE;
    else if (is_sect)
      next_kind = `NPS_KIND_SECT;
    else if (is_half)
      next_kind = `NPS_KIND_HALF;
    else if (is_block)
      next_kind = `NPS_KIND_BLOCK;
    else if (is_chip)
      next_kind = `NPS_KIND_CHIP;
  end

  always @*
  begin
    case (next_kind)
      `NPS_KIND_PAGE:  tmr_count = PAGE_CYCLES;
      `NPS_KIND_SECT:  tmr_count = SECT_CYCLES;
      `NPS_KIND_HALF:  tmr_count = HALF_CYCLES;
      `NPS_KIND_BLOCK: tmr_count = BLOCK_CYCLES;
      default:         tmr_count = CHIP_CYCLES;
    endcase
  end

  // A program started from erase suspend nests; this model keeps the
  // suspended erase plus one nested page program, taken only while the
  // suspended cycle is not running. Limitation: one level of nesting.
  always @(posedge MCLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      state                 <= ST_IDLE;
      kind                  <= `NPS_KIND_NONE;
      run_addr              <= 24'h000000;
      sus_wait              <= {TW{1'b0}};
      resuming              <= 1'b0;
      tmr_load              <= 1'b0;
      nest_load             <= 1'b0;
      WRITE_LATCH_ARMED_OUT <= 1'b0;
      BUSY_OUT              <= 1'b0;
      SUSPENDED_FLAG_OUT    <= 1'b0;
      TARGET_ADDR_OUT       <= 24'h000000;
      START_OUT             <= 1'b0;
      START_KIND_OUT        <= `NPS_KIND_NONE;
      DONE_OUT              <= 1'b0;
    end
    else
    begin
      tmr_load  <= 1'b0;
      nest_load <= 1'b0;
      START_OUT <= 1'b0;
      DONE_OUT  <= 1'b0;
      if (sel_fall || sel_rise)
        TARGET_ADDR_OUT <= addr;
      if (do_wren)
        WRITE_LATCH_ARMED_OUT <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (accept && next_kind != `NPS_KIND_NONE)
          begin
            state          <= ST_RUN;
            kind           <= next_kind;
            run_addr       <= addr;
            tmr_load       <= 1'b1;
            BUSY_OUT       <= 1'b1;
            START_OUT      <= 1'b1;
            START_KIND_OUT <= next_kind;
          end
        end
        ST_RUN:
        begin
          if (resuming)
          begin
            sus_wait <= sus_wait - {{(TW-1){1'b0}}, 1'b1};
            if (sus_wait <= {{(TW-1){1'b0}}, 1'b1})
            begin
              resuming <= 1'b0;
              BUSY_OUT <= 1'b1;
            end
          end
          else if (do_susp)
          begin
            SUSPENDED_FLAG_OUT <= 1'b1;
            sus_wait           <= SUS_CYCLES;
            state              <= ST_SUSP;
          end
          else if (tmr_done)
          begin
            state                 <= ST_IDLE;
            kind                  <= `NPS_KIND_NONE;
            BUSY_OUT              <= 1'b0;
            WRITE_LATCH_ARMED_OUT <= 1'b0;
            DONE_OUT              <= 1'b1;
          end
        end
        ST_SUSP:
        begin
          if (BUSY_OUT)
          begin
            sus_wait <= sus_wait - {{(TW-1){1'b0}}, 1'b1};
            if (sus_wait <= {{(TW-1){1'b0}}, 1'b1})
              BUSY_OUT <= 1'b0;
          end
          else if (do_resume)
          begin
            SUSPENDED_FLAG_OUT <= 1'b0;
            state              <= ST_RUN;
            resuming           <= 1'b1;
            sus_wait           <= RES_CYCLES;
          end
          else if (accept && is_page && kind != `NPS_KIND_PAGE)
          begin
            state          <= ST_NEST;
            nest_load      <= 1'b1;
            BUSY_OUT       <= 1'b1;
            START_OUT      <= 1'b1;
            START_KIND_OUT <= `NPS_KIND_PAGE;
          end
        end
        ST_NEST:
        begin
          if (nest_done)
          begin
            state                 <= ST_SUSP;
            BUSY_OUT              <= 1'b0;
            WRITE_LATCH_ARMED_OUT <= 1'b0;
            DONE_OUT              <= 1'b1;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule // nps_sequencer

/* src/nps_regs.vh */
// Opcodes, field positions and timing constants of the program/erase sequencer
`ifndef NPS_REGS_VH
`define NPS_REGS_VH
`define NPS_OP_WREN      8'h06
`define NPS_OP_RDSR      8'h05
`define NPS_OP_PAGE      8'h02
`define NPS_OP_QPAGE     8'h32
`define NPS_OP_SECT      8'h20
`define NPS_OP_HALF      8'h52
`define NPS_OP_BLOCK     8'hd8
`define NPS_OP_CHIP_A    8'hc7
`define NPS_OP_CHIP_B    8'h60
`define NPS_OP_SUSPEND   8'h75
`define NPS_OP_RESUME    8'h7a
`define NPS_OP_WRSR1     8'h01
`define NPS_OP_WRSR2     8'h31
`define NPS_OP_WRSR3     8'h11
`define NPS_OP_SECPROG   8'h42
`define NPS_OP_SECERASE  8'h44
// Status byte bit positions
`define NPS_ST_BUSY      0
`define NPS_ST_WEL       1
`define NPS_ST_SUS       7
// Address field bounds
`define NPS_SECT_LSB     12
`define NPS_HALF_LSB     15
`define NPS_BLOCK_LSB    16
`define NPS_PAGE_LSB     8
// Kinds of self-timed cycle
`define NPS_KIND_PAGE    3'h1
`define NPS_KIND_SECT    3'h2
`define NPS_KIND_HALF    3'h3
`define NPS_KIND_BLOCK   3'h4
`define NPS_KIND_CHIP    3'h5
`define NPS_KIND_NONE    3'h0
// Resume must raise busy within this time
`define NPS_RESUME_NS    200
`define NPS_CLK_NS       50
`endif

/* src/nps_sync.v */
// Two-flop synchroniser for pin inputs with edge outputs
`timescale 1ns/10ps
module nps_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             clk_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out,
  output wire [WIDTH-1:0] rise_out,
  output wire [WIDTH-1:0] fall_out
);
  reg [WIDTH-1:0] stage;
  reg [WIDTH-1:0] prev;
  // No reset: a synchroniser only follows its pins
  always @(posedge clk_in)
  begin
    stage    <= async_in;
    sync_out <= stage;
    prev     <= sync_out;
  end
  assign rise_out = sync_out & ~prev;
  assign fall_out = ~sync_out & prev;
endmodule // nps_sync

/* src/nps_timer.v */
// Self-timed cycle counter that can pause and continue
`timescale 1ns/10ps
module nps_timer
#(
  parameter WIDTH = 24
)
(
  input  wire             clk_in,
  input  wire             reset_n_in,
  input  wire             load_in,
  input  wire [WIDTH-1:0] count_in,
  input  wire             run_in,
  output wire             done_out
);
  reg [WIDTH-1:0] remain;
  always @(posedge clk_in)
  begin
    if (!reset_n_in)
      remain <= {WIDTH{1'b0}};
    else if (load_in)
      remain <= count_in;
    else if (run_in && remain != {WIDTH{1'b0}})
      remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
  end
  assign done_out = run_in && (remain == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // nps_timer

/* bench/nps_monitor.sv */
// Pin-level checks on the program/erase sequencer
`timescale 1ns/10ps
module nps_monitor
#(
  parameter int SUS_CYCLES = 10
)
(
  input wire       MCLK_IN,
  input wire       RESET_N_IN,
  input wire       SEL_N_IN,
  input wire       TARGET_PROTECTED_IN,
  input wire       PROTECT_SIZE_BIT2_IN,
  input wire       PROTECT_SIZE_BIT1_IN,
  input wire       PROTECT_SIZE_BIT0_IN,
  input wire       WRITE_LATCH_ARMED_OUT,
  input wire       BUSY_OUT,
  input wire       SUSPENDED_FLAG_OUT,
  input wire       LANE_ONE_OE_N_OUT,
  input wire       START_OUT,
  input wire [2:0] START_KIND_OUT,
  input wire       DONE_OUT
);
  localparam int SUS_LIM = SUS_CYCLES + 4;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  a_start_needs_latch: assert property (START_OUT |-> WRITE_LATCH_ARMED_OUT)
    else $error("cycle started without armed latch");
  a_start_one_pulse: assert property (START_OUT |=> !START_OUT && BUSY_OUT)
    else $error("start not a pulse or busy missing");
  a_cycle_min_len: assert property (START_OUT |=> !DONE_OUT [*8])
    else $error("cycle finished too early");
  a_done_clears_latch: assert property (DONE_OUT |-> ##[0:1] (!BUSY_OUT && !WRITE_LATCH_ARMED_OUT))
    else $error("completion left busy or latch set");
  a_chip_unprotected: assert property (START_OUT && START_KIND_OUT == 3'h5 |->
    !(PROTECT_SIZE_BIT2_IN || PROTECT_SIZE_BIT1_IN || PROTECT_SIZE_BIT0_IN))
    else $error("chip erase under protection");
  a_target_unprotected: assert property (START_OUT && START_KIND_OUT != 3'h5 |-> !TARGET_PROTECTED_IN)
    else $error("protected target started");
  a_suspend_needs_busy: assert property ($rose(SUSPENDED_FLAG_OUT) |-> $past(BUSY_OUT))
    else $error("suspend taken while idle");
  a_suspend_drops_busy: assert property ($rose(SUSPENDED_FLAG_OUT) |-> ##[0:SUS_LIM] !BUSY_OUT)
    else $error("busy stayed after suspend");
  a_resume_sets_busy: assert property ($fell(SUSPENDED_FLAG_OUT) |-> ##[0:4] BUSY_OUT)
    else $error("busy late after resume");
  a_idle_lane_free: assert property (SEL_N_IN [*4] |-> LANE_ONE_OE_N_OUT)
    else $error("lane driven while deselected");
endmodule // nps_monitor

/* bench/nps_host_model.sv */
// Serial host model: frames with chip select, slow serial clock, one or four lanes
`timescale 1ns/10ps
module nps_host_model
(
  input  wire        clk_in,
  output logic       sel_n_out = 1'b1,
  output logic       sclk_out = 1'b0,
  output logic [3:0] lane_out = 4'h0
);
  // Lanes toggle between frames so a stale bit can never pass for data
  always @(posedge clk_in)
    if (sel_n_out)
      lane_out <= ~lane_out;
  // Opcode always on one lane; quad frames carry the rest as nibbles, high first
  task automatic frame(input logic [7:0] op, input logic [55:0] rest, input int nbits, input bit quad);
    logic [63:0] v;
    int n;
    v = {op, rest};
    sel_n_out <= 1'b0;
    @(posedge clk_in);
    for (n = 0; n < 8 + (quad ? nbits / 4 : nbits); n++)
    begin
      lane_out <= (quad && n >= 8) ? v[63:60] : {3'h0, v[63]};
      v = v << ((quad && n >= 8) ? 4 : 1);
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
    end
    sclk_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    sel_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
endmodule // nps_host_model

/* bench/tb_top.sv */
// Self-checking bench for the program/erase sequencer
`timescale 1ns/10ps
module tb_top;
  logic       mclk = 0, rst_n = 0, quad = 0, tprot = 0, ps0 = 0, ign = 0;
  logic [3:0] pv = 4'h0;
  wire        sel_n, sclk, oe_n, one_o, armed, busy, susp, pwr, start, done;
  wire [3:0]  lane;
  wire [23:0] taddr;
  wire [7:0]  pidx, pdat;
  wire [2:0]  kind;
  logic [2:0] exp_k[$];
  logic [15:0] exp_w[$];
  int         fail_count = 0, n_checks = 0, seed = 81229, cyc = 0;
  nps_host_model h (.clk_in(mclk), .sel_n_out(sel_n), .sclk_out(sclk), .lane_out(lane));
  nps_sequencer #(.PAGE_CYCLES(24'd60), .SECT_CYCLES(24'd300), .HALF_CYCLES(24'd80), .BLOCK_CYCLES(24'd100),
    .CHIP_CYCLES(24'd400), .SUS_CYCLES(24'd10)) dut_u (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .SEL_N_IN(sel_n),
    .SCLK_IN(sclk), .LANE_ZERO_IN(lane[0]), .LANE_ONE_IN(oe_n ? lane[1] : one_o), .LANE_TWO_IN(lane[2]),
    .LANE_THREE_IN(lane[3]), .LANE_ONE_OUT(one_o), .LANE_ONE_OE_N_OUT(oe_n), .QUAD_LANES_ON_IN(quad),
    .PROTECT_FROM_BOTTOM_IN(pv[3]), .SMALL_GRANULE_PROTECT_IN(pv[2]), .PROTECT_SIZE_BIT2_IN(pv[1]),
    .PROTECT_SIZE_BIT1_IN(pv[0]), .PROTECT_SIZE_BIT0_IN(ps0), .TARGET_PROTECTED_IN(tprot),
    .TARGET_ADDR_OUT(taddr), .WRITE_LATCH_ARMED_OUT(armed), .BUSY_OUT(busy), .SUSPENDED_FLAG_OUT(susp),
    .PAGE_WR_OUT(pwr), .PAGE_WR_INDEX_OUT(pidx), .PAGE_WR_DATA_OUT(pdat), .START_OUT(start),
    .START_KIND_OUT(kind), .DONE_OUT(done));
  initial
    forever #25 mclk = ~mclk;
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Refused commands show up as a start with nothing queued
  always @(posedge mclk)
  begin
    cyc++;
    if (start)
      check("start kind", kind, exp_k.size() ? exp_k.pop_front() : 3'h7);
    if (pwr && !ign)
      check("page byte", {pidx, pdat}, exp_w.size() ? exp_w.pop_front() : 16'hxxxx);
    if (cyc == 40000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic idle_wait;
    int n;
    for (n = 0; n < 3000 && busy !== 1'b0; n++)
      @(posedge mclk);
    check("busy idle", busy, 1'b0);
  endtask
  task automatic erase(input logic [7:0] op, input logic [23:0] a, input int nb, input logic [2:0] k);
    h.frame(8'h06, '0, 0, 0);
    check("latch", armed, 1'b1);
    if (k)
      exp_k.push_back(k);
    h.frame(op, {a, 32'h0}, nb, 0);
    if (nb == 24)
      check("target", taddr, a);
    idle_wait();
  endtask
  task automatic page(input logic [23:0] a, input int nb, input bit q, input bit ok);
    logic [15:0] d;
    int i;
    d = $random(seed);
    h.frame(8'h06, '0, 0, 0);
    ign = !ok;
    if (ok)
      exp_k.push_back(3'h1);
    for (i = 0; ok && i < nb; i++)
      exp_w.push_back({a[7:0] + 8'(i), d[15 - 8 * i -: 8]});
    h.frame(q ? 8'h32 : 8'h02, {a, d, 16'h0}, 24 + 8 * nb, q);
    ign = 0;
    if (ok)
      idle_wait();
  endtask
  logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    pv[3:2] <= 2'($random(seed));
    repeat (4) @(posedge mclk);
    page(24'h0130ff, 2, 0, 1);
    check("latch after", armed, 1'b0);
    h.frame(8'h20, {24'h003000, 32'h0}, 24, 0);
    foreach (ops[i])
      erase(ops[i], $random(seed), i < 3 ? 24 : 0, i < 3 ? 3'(i + 2) : 3'h5);
    $display("test page and erase finished");
    erase(8'h20, 24'h004000, 27, 0);
    erase(8'hc7, 24'h0, 8, 0);
    tprot <= 1'b1;
    erase(8'h20, 24'h006000, 24, 0);
    tprot <= 1'b0;
    ps0 <= 1'b1;
    erase(8'h60, 24'h0, 0, 0);
    ps0 <= 1'b0;
    pv[1] <= 1'b1;
    erase(8'hc7, 24'h0, 0, 0);
    pv[1] <= 1'b0;
    pv[0] <= 1'b1;
    erase(8'h60, 24'h0, 0, 0);
    pv[0] <= 1'b0;
    page(24'h020010, 2, 1, 0);
    quad <= 1'b1;
    page(24'h020020, 2, 1, 1);
    quad <= 1'b0;
    $display("test refusals finished");
    h.frame(8'h06, '0, 0, 0);
    exp_k.push_back(3'h2);
    h.frame(8'h20, {24'h001000, 32'h0}, 24, 0);
    h.frame(8'h75, '0, 0, 0);
    repeat (16) @(posedge mclk);
    check("suspended", {susp, busy}, 2'b10);
    erase(8'h20, 24'h002000, 24, 0);
    page(24'h001010, 1, 0, 0);
    page(24'h005000, 1, 0, 1);
    h.frame(8'h7a, '0, 0, 0);
    repeat (4) @(posedge mclk);
    check("resumed", {susp, busy}, 2'b01);
    idle_wait();
    h.frame(8'h06, '0, 0, 0);
    exp_k.push_back(3'h5);
    h.frame(8'hc7, '0, 0, 0);
    h.frame(8'h75, '0, 0, 0);
    check("chip suspend", {susp, busy}, 2'b01);
    idle_wait();
    $display("test suspend finished");
    check("queues", exp_k.size() + exp_w.size(), 0);
    give_verdict();
  end
endmodule // tb_top
bind nps_sequencer nps_monitor #(.SUS_CYCLES(10)) mon_u (.MCLK_IN, .RESET_N_IN, .SEL_N_IN, .TARGET_PROTECTED_IN,
  .PROTECT_SIZE_BIT2_IN, .PROTECT_SIZE_BIT1_IN, .PROTECT_SIZE_BIT0_IN, .WRITE_LATCH_ARMED_OUT, .BUSY_OUT,
  .SUSPENDED_FLAG_OUT, .LANE_ONE_OE_N_OUT, .START_OUT, .START_KIND_OUT, .DONE_OUT);
